// [rtl/bsc_consts.svh]
// Function
// (R01) discard count 2^15, or 2^10 when short
// (R02) count starts when completion heads queue
// (R03) expiry without retry drops entry, sets flag
// (R04) primary timeout select reads zero
// (R05) no fast back-to-back; enable reads zero
// (R06) reset pin follows secondary reset bit
// (R07) reset bit clears secondary side, buffers
// (R08) primary side and registers unaffected
// (R09) software honours pci reset timing
// (R10) abort quiet: ur gives all-ones, writes complete
// (R11) abort quiet: posted master-abort data discarded
// (R12) abort report: ur gives target-abort
// (R13) abort report: posted abort sends error message
// (R14) vga io decode 16 bits or 10
// (R15) retry clears counter; counts pci clock only
// (R16) discard flag set on expiry, write-one clear
// (R17) discard error enable sends error message
// (R18) vga enable forwards vga memory regardless
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH
`define BSC_ADDR_CTRL       8'h3C
`define BSC_ADDR_SIDEBAND   8'h40
`define BSC_BIT_INT_LINE    0
`define BSC_BIT_INT_PIN     8
`define BSC_BIT_PERR_RESP   16
`define BSC_BIT_SERR_FWD    17
`define BSC_BIT_ISA_EN      18
`define BSC_BIT_VGA_EN      19
`define BSC_BIT_VGA_WIDE    20
`define BSC_BIT_MA_MODE     21
`define BSC_BIT_SEC_RESET   22
`define BSC_BIT_FAST_B2B    23
`define BSC_BIT_PRI_TMO     24
`define BSC_BIT_SEC_SHORT   25
`define BSC_BIT_DISC_STAT   26
`define BSC_BIT_DISC_ERR    27
`define BSC_RESET_CTRL      32'h0000_00FF
`define BSC_LONG_EXP        15
`define BSC_SHORT_EXP       10
`define BSC_VGA_MEM_LO      32'h000A_0000
`define BSC_VGA_MEM_HI      32'h000B_FFFF
`define BSC_VGA_IO_A_LO     10'h3B0
`define BSC_VGA_IO_A_HI     10'h3BB
`define BSC_VGA_IO_B_LO     10'h3C0
`define BSC_VGA_IO_B_HI     10'h3DF
`define BSC_ALL_ONES        32'hFFFF_FFFF
`endif

// [rtl/bsc_pkg.sv]
package bsc_pkg;
    typedef enum logic [1:0] {
        BSC_IDLE  = 2'b00,
        BSC_COUNT = 2'b01,
        BSC_DROP  = 2'b11
    } bsc_disc_e;

    typedef enum logic [1:0] {
        BSC_ANS_NONE   = 2'b00,
        BSC_ANS_ONES   = 2'b01,
        BSC_ANS_TABORT = 2'b10
    } bsc_ans_e;

    typedef struct packed {
        logic        valid;
        logic        isMem;
        logic [31:0] addr;
    } bsc_dec_s;

    typedef struct packed {
        logic urNonPosted;
        logic isRead;
        logic postedAbort;
    } bsc_abort_s;
endpackage : bsc_pkg

// [rtl/bsc_discard_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.svh"
module bsc_discard_timer
    import bsc_pkg::*;
#(
    parameter int LONG_EXP  = `BSC_LONG_EXP,
    parameter int SHORT_EXP = `BSC_SHORT_EXP
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    input  wire logic secReset,
    // control
    input  wire logic shortSel,
    input  wire logic headReady,
    input  wire logic retried,
    // result
    output logic      dropPulse,
    output logic      counting
);
    localparam int W = LONG_EXP + 1;
    bsc_disc_e      state_r;
    logic [W-1:0]   count_r;
    logic [W-1:0]   limit;

    // R01
    assign limit = shortSel ? (W'(1) << SHORT_EXP) : (W'(1) << LONG_EXP);
    assign counting = (state_r == BSC_COUNT);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_r   <= BSC_IDLE;
            count_r   <= '0;
            dropPulse <= 1'b0;
        end else if (clkEn) begin
            dropPulse <= 1'b0;
            if (secReset) begin
                state_r <= BSC_IDLE; // R07
                count_r <= '0;
            end else begin
                case (state_r)
                    BSC_IDLE: begin
                        count_r <= '0;
                        if (headReady && !retried) state_r <= BSC_COUNT; // R02
                    end
                    BSC_COUNT: begin
                        if (retried) begin
                            state_r <= BSC_IDLE; // R15
                            count_r <= '0;
                        end else if (count_r + W'(1) >= limit) begin
                            state_r   <= BSC_DROP; // R03
                            dropPulse <= 1'b1;
                        end else begin
                            count_r <= count_r + W'(1);
                        end
                    end
                    BSC_DROP: begin
                        state_r <= BSC_IDLE;
                        count_r <= '0;
                    end
                    default: state_r <= BSC_IDLE;
                endcase
            end
        end
    end
endmodule : bsc_discard_timer
`default_nettype wire

// [rtl/bsc_secondary_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.svh"
module bsc_secondary_ctrl
    import bsc_pkg::*;
(
    // clock and reset (clk_sys is the secondary pci clock)
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // delayed transaction queue
    input  wire logic        headReady,
    input  wire logic        retried,
    output logic             dropDelayed,
    output logic             discardCounting,
    // abort handling
    input  wire bsc_abort_s  abortIn,
    input  wire logic        cmdSerrEnable,
    output bsc_ans_e         answer,
    output logic [31:0]      readFill,
    output logic             postedDiscard,
    output logic             errMsgReq,
    // vga decode
    input  wire bsc_dec_s    decIn,
    output logic             vgaHit,
    // secondary reset
    output logic             pciRst_n,
    output logic             secInit
);
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic        dropPulse;
    logic        wrCtrl;
    logic        rdAcc;
    logic        known;

    assign pready  = 1'b1;
    assign known   = (paddr == `BSC_ADDR_CTRL) || (paddr == `BSC_ADDR_SIDEBAND);
    assign pslverr = psel && penable && !known;
    assign wrCtrl  = psel && penable && pwrite && (paddr == `BSC_ADDR_CTRL);
    assign rdAcc   = psel && !penable && !pwrite;

    function automatic logic [31:0] strobeMerge(input logic [31:0] oldV,
                                                input logic [31:0] newV,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = oldV;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = newV[i*8 +: 8];
        end
        return res;
    endfunction : strobeMerge

    function automatic logic inRange10(input logic [9:0] a,
                                       input logic [9:0] lo,
                                       input logic [9:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : inRange10

    // control register next value
    always_comb begin
        logic [31:0] m;
        m        = strobeMerge(ctrl_r, pwdata, pstrb);
        ctrl_nxt = ctrl_r;
        if (wrCtrl) begin
            ctrl_nxt = m;
            ctrl_nxt[`BSC_BIT_DISC_STAT] = ctrl_r[`BSC_BIT_DISC_STAT]
                                           & ~(pstrb[3] & pwdata[`BSC_BIT_DISC_STAT]); // R16
        end
        ctrl_nxt[`BSC_BIT_PRI_TMO]  = 1'b0; // R04
        ctrl_nxt[`BSC_BIT_FAST_B2B] = 1'b0; // R05
        ctrl_nxt[31:28]             = 4'h0;
        ctrl_nxt[15:8]              = ctrl_r[15:8];
        // set beats clear
        if (dropPulse) ctrl_nxt[`BSC_BIT_DISC_STAT] = 1'b1; // R16
    end

    // register file is never touched by secondary reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= `BSC_RESET_CTRL;
        end else if (clkEn) begin
            ctrl_r <= ctrl_nxt; // R08
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (clkEn && rdAcc) begin
            case (paddr)
                `BSC_ADDR_CTRL:     prdata <= ctrl_r;
                `BSC_ADDR_SIDEBAND: prdata <= {30'h0, discardCounting, pciRst_n};
                default:            prdata <= 32'h0000_0000;
            endcase
        end
    end

    // pin follows the bit with one register stage, no stretching
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pciRst_n <= 1'b0;
            secInit  <= 1'b1;
        end else if (clkEn) begin
            pciRst_n <= ~ctrl_r[`BSC_BIT_SEC_RESET]; // R06 R09
            secInit  <= ctrl_r[`BSC_BIT_SEC_RESET]; // R07
        end
    end

    bsc_discard_timer u_timer (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .clkEn     (clkEn),
        .secReset  (ctrl_r[`BSC_BIT_SEC_RESET]),
        .shortSel  (ctrl_r[`BSC_BIT_SEC_SHORT]),
        .headReady (headReady),
        .retried   (retried),
        .dropPulse (dropPulse),
        .counting  (discardCounting)
    );

    assign dropDelayed = dropPulse; // R03

    // abort answers registered one cycle after the event
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            answer        <= BSC_ANS_NONE;
            readFill      <= 32'h0000_0000;
            postedDiscard <= 1'b0;
            errMsgReq     <= 1'b0;
        end else if (clkEn) begin
            answer        <= BSC_ANS_NONE;
            readFill      <= 32'h0000_0000;
            postedDiscard <= 1'b0;
            errMsgReq     <= 1'b0;
            if (abortIn.urNonPosted) begin
                if (ctrl_r[`BSC_BIT_MA_MODE]) begin
                    answer <= BSC_ANS_TABORT; // R12
                end else begin
                    answer   <= BSC_ANS_ONES; // R10
                    readFill <= abortIn.isRead ? `BSC_ALL_ONES : 32'h0000_0000;
                end
            end
            if (abortIn.postedAbort) begin
                postedDiscard <= 1'b1; // R11
                if (ctrl_r[`BSC_BIT_MA_MODE] && cmdSerrEnable) errMsgReq <= 1'b1; // R13
            end
            if (dropPulse && ctrl_r[`BSC_BIT_DISC_ERR]) errMsgReq <= 1'b1; // R17
        end
    end

    // vga decode; no window checks, forwarding is unconditional on hit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            vgaHit <= 1'b0;
        end else if (clkEn) begin
            vgaHit <= 1'b0;
            if (decIn.valid && ctrl_r[`BSC_BIT_VGA_EN]) begin
                if (decIn.isMem) begin
                    vgaHit <= (decIn.addr >= `BSC_VGA_MEM_LO)
                              && (decIn.addr <= `BSC_VGA_MEM_HI); // R18
                end else begin
                    vgaHit <= (decIn.addr[31:16] == 16'h0000)
                              && (inRange10(decIn.addr[9:0], `BSC_VGA_IO_A_LO, `BSC_VGA_IO_A_HI)
                               || inRange10(decIn.addr[9:0], `BSC_VGA_IO_B_LO, `BSC_VGA_IO_B_HI))
                              && (!ctrl_r[`BSC_BIT_VGA_WIDE]
                               || decIn.addr[15:10] == 6'h00); // R14
                end
            end
        end
    end
endmodule : bsc_secondary_ctrl
`default_nettype wire

// [bench/bsc_ctrl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module bsc_ctrl_monitor
    import bsc_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    // side outputs
    input wire bsc_abort_s  abortIn,
    input wire bsc_ans_e    answer,
    input wire logic        postedDiscard,
    input wire logic        dropDelayed,
    input wire logic        discardCounting,
    input wire logic        pciRst_n,
    input wire logic        secInit,
    input wire logic        vgaHit
);
    logic maMode;
    wire  ctlWr = psel && penable && pwrite && paddr == 8'h3C;
    // shadow of the abort mode bit, seen only through the bus
    always_ff @(posedge clk_sys or posedge sys_rst)
        if (sys_rst) maMode <= 1'b0;
        else if (ctlWr && pstrb[2]) maMode <= pwdata[21];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_PIN_MIRROR: assert property (pciRst_n == !secInit)
        else $error("reset pin and init disagree");
    AST_PIN_FOLLOW: assert property (ctlWr && pstrb[2] |-> ##2
        pciRst_n == !$past(pwdata[22], 2))
        else $error("reset pin does not follow bit");
    AST_ZERO_WAIT: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    AST_UNMAPPED: assert property (psel && penable && paddr != 8'h3C && paddr != 8'h40 |-> pslverr)
        else $error("unmapped access without error");
    // mode as it stood when the ur arrived, not after a write in that cycle
    AST_UR_ANSWER: assert property (abortIn.urNonPosted |=>
        answer == ($past(maMode) ? BSC_ANS_TABORT : BSC_ANS_ONES))
        else $error("wrong answer to ur");
    AST_POSTED_DROP: assert property (abortIn.postedAbort && !maMode |=> postedDiscard)
        else $error("posted abort not discarded");
    AST_DROP_PULSE: assert property (dropDelayed |=> !dropDelayed)
        else $error("drop longer than one cycle");
    // secInit and the timer both react to the bit at the same edge
    AST_INIT_STOP: assert property (secInit |-> !discardCounting)
        else $error("counting under secondary reset");
    cover property (dropDelayed);
    cover property (answer == BSC_ANS_TABORT);
    cover property (vgaHit);
endmodule : bsc_ctrl_monitor
bind bsc_secondary_ctrl bsc_ctrl_monitor bsc_ctrl_monitor_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .abortIn(abortIn),
    .answer(answer), .postedDiscard(postedDiscard), .dropDelayed(dropDelayed),
    .discardCounting(discardCounting), .pciRst_n(pciRst_n), .secInit(secInit), .vgaHit(vgaHit));
`default_nettype wire

// [bench/bsc_pci_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bsc_pci_master_model (
    // bench control
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic        dropped,
    input  wire logic [10:0] retryAfter,
    // toward the bridge
    output logic             headReady,
    output logic             retried
);
    logic [10:0] waitCnt;
    // zero retryAfter models a master that never comes back
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            headReady <= 1'b0;
            retried <= 1'b0;
            waitCnt <= 11'h000;
        end else begin
            retried <= 1'b0;
            waitCnt <= waitCnt + 11'h001;
            if (start) begin
                headReady <= 1'b1;
                waitCnt <= 11'h000;
            end else if (dropped || retried) begin
                headReady <= 1'b0;
            end else if (headReady && retryAfter != 11'h000 && waitCnt == retryAfter) begin
                retried <= 1'b1;
            end
        end
    end
endmodule : bsc_pci_master_model
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bsc_pkg::*;
    logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, readFill, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, start = 1'b0, headReady, retried, dropDelayed, discardCounting;
    logic cmdSerrEnable = 1'b0, postedDiscard, errMsgReq, vgaHit, pciRst_n, secInit;
    logic errSeen = 1'b0, dropSeen = 1'b0, err;
    logic [10:0] retryAfter = 11'h000;
    logic [31:0] vCfg[5] = '{32'h0008_00FF, 32'h0018_00FF, 32'h0018_00FF, 32'h0008_00FF,
        32'h0000_00FF};
    logic [31:0] vAddr[5] = '{32'h17B0, 32'h17B0, 32'h03C5, 32'hA_0000, 32'hA_0000};
    logic [4:0] vHit = 5'b01101;
    bsc_abort_s abortIn = '0;
    bsc_dec_s decIn = '0;
    bsc_ans_e answer;
    int n_fail = 0, checks_done = 0, cnt;
    bsc_secondary_ctrl bsc_secondary_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .headReady(headReady),
        .retried(retried), .dropDelayed(dropDelayed), .discardCounting(discardCounting),
        .abortIn(abortIn), .cmdSerrEnable(cmdSerrEnable), .answer(answer), .readFill(readFill),
        .postedDiscard(postedDiscard), .errMsgReq(errMsgReq), .decIn(decIn), .vgaHit(vgaHit),
        .pciRst_n(pciRst_n), .secInit(secInit));
    bsc_pci_master_model bsc_pci_master_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .start(start), .dropped(dropDelayed), .retryAfter(retryAfter), .headReady(headReady),
        .retried(retried));
    initial forever #50 clk_sys = ~clk_sys;
    // pulses are caught here so slow checks cannot miss them
    always @(posedge clk_sys) begin
        if (errMsgReq) errSeen <= 1'b1;
        if (dropDelayed) dropSeen <= 1'b1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20 && !(i > 0 && pready); i++) @(posedge clk_sys);
        if (i == 20) begin
            n_fail++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdc
    task automatic pulseStart(input int lim);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        for (cnt = 0; cnt < lim && !dropDelayed; cnt++) @(posedge clk_sys);
    endtask : pulseStart
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdc(8'h3C, 32'h0000_00FF);
        apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        rdc(8'h3C, 32'h0A7F_00FF);
        check(pciRst_n, 1'b0);
        check(secInit, 1'b1);
        repeat (10) @(posedge clk_sys);
        apb(1'b1, 8'h3C, 32'h0000_00FF);
        rdc(8'h40, 32'h1);
        apb(1'b1, 8'h80, 32'hFFFF_FFFF);
        check(err, 1'b1);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, 8'h3C, s ? 32'h0A00_00FF : 32'h0800_00FF);
            errSeen <= 1'b0;
            pulseStart(40000);
            check(cnt >= (s ? 1024 : 32768) && cnt <= (s ? 1028 : 32772), 1'b1);
            repeat (3) @(posedge clk_sys);
            check(errSeen, 1'b1);
            rdc(8'h3C, s ? 32'h0E00_00FF : 32'h0C00_00FF);
            apb(1'b1, 8'h3C, s ? 32'h0E00_00FF : 32'h0C00_00FF);
            rdc(8'h3C, s ? 32'h0A00_00FF : 32'h0800_00FF);
        end
        for (int k = 0; k < 2; k++) begin
            retryAfter <= k ? 11'h000 : 11'h064;
            dropSeen <= 1'b0;
            pulseStart(200);
            if (k) apb(1'b1, 8'h3C, 32'h0240_00FF);
            repeat (1200) @(posedge clk_sys);
            check(dropSeen, 1'b0);
            check(discardCounting, 1'b0);
        end
        apb(1'b1, 8'h3C, 32'h0200_00FF);
        repeat (1100) @(posedge clk_sys);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, 8'h3C, m ? 32'h0020_00FF : 32'h0000_00FF);
            cmdSerrEnable <= (m != 2);
            errSeen <= 1'b0;
            abortIn <= '{1'b1, 1'b1, 1'b0};
            @(posedge clk_sys);
            abortIn <= '{1'b0, 1'b0, 1'b1};
            @(negedge clk_sys);
            check(answer, m ? BSC_ANS_TABORT : BSC_ANS_ONES);
            if (m == 0) check(readFill, 32'hFFFF_FFFF);
            @(posedge clk_sys);
            abortIn <= '0;
            @(negedge clk_sys);
            check(postedDiscard, 1'b1);
            repeat (3) @(posedge clk_sys);
            check(errSeen, m == 1);
        end
        for (int v = 0; v < 5; v++) begin
            apb(1'b1, 8'h3C, vCfg[v]);
            decIn <= '{1'b1, v > 2, vAddr[v]};
            @(posedge clk_sys);
            decIn <= '0;
            @(negedge clk_sys);
            check(vgaHit, vHit[v]);
        end
        // mid-run system reset: pin held, register file back to reset value
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check(pciRst_n, 1'b0);
        sys_rst <= 1'b0;
        rdc(8'h3C, 32'h0000_00FF);
        final_report();
    end
endmodule : tb
`default_nettype wire
